// [sim/sild_checker.sv]
// Port assertions for the lamp controller
`timescale 1ns/1ps
`default_nettype none
module sild_checker
	import sild_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [13:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        link_up,
	input wire logic        role_master,
	input wire logic [2:0]  lamp
);
	logic        ph_q;
	logic        wr_q;
	logic [11:0] idx_q;
	logic [15:0] main_q;
	logic [15:0] aux_q;
	logic        take;
	logic        rd;
	logic        plain;
	logic [3:0]  sel;
	assign take = hsel & hready & htrans[1];
	assign rd = take & ~hwrite;
	assign plain = (aux_q == 16'h0000);
	assign sel = main_q[3:0];
	// Shadow config words; lamp checks hold only while the aux word is zero (no force, no inversion)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q <= 1'h0;
			wr_q <= 1'h0;
			idx_q <= 12'h000;
			main_q <= SILD_RST_CFG_MAIN;
			aux_q <= SILD_RST_CFG_AUX;
		end else begin
			ph_q <= take;
			wr_q <= hwrite;
			idx_q <= haddr[13:2];
			if (ph_q && wr_q && idx_q == SILD_IDX_CFG_MAIN)
				main_q <= hwdata[15:0] & SILD_MASK_MAIN;
			if (ph_q && wr_q && idx_q == SILD_IDX_CFG_AUX)
				aux_q <= hwdata[15:0] & SILD_MASK_AUX;
		end
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_hold(logic [3:0] c, logic l);
		(plain && sel == c && link_up == l)[*8];
	endsequence
	sequence s_role;
		(plain && link_up && ((sel == 4'h4 && role_master) || (sel == 4'h5 && !role_master)))[*8];
	endsequence
	property p_ready; hreadyout == 1'h1; endproperty
	property p_okay; hresp == 1'h0; endproperty
	property p_upper; hrdata[31:16] == 16'h0000; endproperty
	property p_hold; !$past(rd) |-> $stable(hrdata); endproperty
	property p_link_on; s_hold(4'h0, 1'h1) |-> lamp[0]; endproperty
	property p_link_off; s_hold(4'h0, 1'h0) |-> !lamp[0]; endproperty
	property p_role; s_role |-> lamp[0]; endproperty
	property p_lost; plain && sel == 4'h9 && $fell(link_up) |-> ##[2:8] lamp[0]; endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	a_okay: assert property (p_okay) else $error("hresp not okay");
	a_upper: assert property (p_upper) else $error("hrdata upper half set");
	a_hold: assert property (p_hold) else $error("hrdata moved without read");
	a_link_on: assert property (p_link_on) else $error("link lamp dark");
	a_link_off: assert property (p_link_off) else $error("link lamp lit");
	a_role: assert property (p_role) else $error("role lamp dark");
	a_lost: assert property (p_lost) else $error("lost lamp not set");
endmodule : sild_checker
`default_nettype wire

// [sim/sild_lamps.sv]
// Model of the external lamps: counts switch-ons and lit cycles
`timescale 1ns/1ps
`default_nettype none
module sild_lamps (
	input  wire logic             hclk,
	input  wire logic             clr,
	input  wire logic [2:0]       lamp,
	output logic      [2:0][15:0] rises,
	output logic      [2:0][15:0] lit
);
	logic [2:0] prev;
	// Counts are only meaningful after a clear from the bench
	always_ff @(posedge hclk) begin
		prev <= lamp;
		for (int i = 0; i < 3; i++) begin
			rises[i] <= clr ? 16'h0 : rises[i] + 16'(lamp[i] & ~prev[i]);
			lit[i] <= clr ? 16'h0 : lit[i] + 16'(lamp[i]);
		end
	end
endmodule : sild_lamps
`default_nettype wire

// [sim/testbench.sv]
// Self-checking testbench for the lamp controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sild_pkg::*;
	localparam int UNIT = 4;
	localparam int STR = 8;
	localparam logic [13:0] A_MAIN = {SILD_IDX_CFG_MAIN, 2'h0};
	localparam logic [13:0] A_AUX = {SILD_IDX_CFG_AUX, 2'h0};
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, clr = 1'h0;
	logic [13:0] haddr = 14'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic link_up = 1'h0, role_master = 1'h0, tx_act = 1'h0, rx_act = 1'h0;
	logic pat_err = 1'h0, if_tx_err = 1'h0, if_rx_err = 1'h0;
	logic status_rd = 1'h0, pat_err_clr = 1'h0;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp;
	wire logic [2:0] lamp;
	logic [2:0][15:0] rises, lit;
	logic [31:0] rd;
	int miscompares = 0, num_checks = 0, cyc = 0;
	always #20 hclk = ~hclk;
	sild_top #(.BLINK_UNIT(UNIT), .STRETCH(STR)) sild_top_inst (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .link_up, .role_master, .tx_act, .rx_act, .pat_err,
		.if_tx_err, .if_rx_err, .status_rd, .pat_err_clr, .lamp);
	sild_lamps sild_lamps_inst (.hclk, .clr, .lamp, .rises, .lit);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task test_done;
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task wait_c(input int n);
		repeat (n) @(posedge hclk);
	endtask : wait_c
	// Entered just after an edge; holds each phase until hready is seen
	task bus(input logic w, input logic [13:0] a, input logic [15:0] d);
		{hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, 16'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : bus
	// Only defined selector codes are ever written here
	task cfg(input logic [15:0] d);
		bus(1'h1, A_MAIN, d);
		wait_c(12);
	endtask : cfg
	task pulse_clr;
		clr <= 1'h1;
		wait_c(1);
		clr <= 1'h0;
	endtask : pulse_clr
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_regs;
		bus(1'h0, A_MAIN, 16'h0); check("main_rst", rd, 32'h2610);
		bus(1'h0, A_AUX, 16'h0); check("aux_rst", rd, 32'h0000);
		bus(1'h1, A_MAIN, 16'hffff);
		bus(1'h0, A_MAIN, 16'h0); check("main_rw", rd, 32'h7fff);
		bus(1'h1, A_AUX, 16'hffff);
		bus(1'h0, A_AUX, 16'h0); check("aux_rw", rd, 32'h01ff);
		bus(1'h1, A_AUX, 16'h0);
		bus(1'h1, 14'h1148, 16'h1234);
		bus(1'h0, 14'h1148, 16'h0); check("unmapped", rd, 32'h0);
	endtask : t_regs
	task t_link;
		cfg(16'h0010);
		link_up <= 1'h1;
		wait_c(12); check("link_on", 32'(lamp), 32'h7);
		link_up <= 1'h0;
		wait_c(12); check("link_off", 32'(lamp), 32'h0);
		// Lamp 0 forced on, lamp 1 inverted, lamp 2 forced off
		bus(1'h1, A_AUX, 16'h010e);
		wait_c(4); check("aux_force", 32'(lamp), 32'h3);
		bus(1'h1, A_AUX, 16'h0000);
	endtask : t_link
	task t_role;
		{link_up, role_master} <= 2'h3;
		cfg(16'h0054); check("master", 32'(lamp), 32'h5);
		role_master <= 1'h0;
		wait_c(12); check("slave", 32'(lamp), 32'h6);
	endtask : t_role
	// Each rate over four periods; last entry is tx-only code with rx traffic
	task t_blink;
		int per [4];
		per = '{SILD_PER_MS_0, SILD_PER_MS_1, SILD_PER_MS_2, SILD_PER_MS_3};
		for (int i = 0; i < 5; i++) begin
			{tx_act, rx_act} <= (i < 2) ? 2'h2 : 2'h1;
			cfg({2'h0, 2'(i % 4), 8'h0, 4'(i % 3 + 1)});
			pulse_clr;
			wait_c(4 * per[i % 4] * UNIT + 1);
			check("blink", 32'(rises[0]), (i == 4) ? 32'h0 : 32'h4);
		end
		{tx_act, rx_act} <= 2'h0;
	endtask : t_blink
	task t_latch;
		cfg(16'h0009);
		// Clear the drop left by the link scenario before making a new one
		status_rd <= 1'h1;
		wait_c(1);
		status_rd <= 1'h0;
		wait_c(4); check("lost_pre", 32'(lamp[0]), 32'h0);
		link_up <= 1'h0;
		wait_c(12);
		link_up <= 1'h1;
		wait_c(12); check("lost_on", 32'(lamp[0]), 32'h1);
		status_rd <= 1'h1;
		wait_c(1);
		status_rd <= 1'h0;
		wait_c(4); check("lost_clr", 32'(lamp[0]), 32'h0);
		cfg(16'h000a);
		pat_err <= 1'h1;
		wait_c(5);
		pat_err <= 1'h0;
		wait_c(12); check("pat_on", 32'(lamp[0]), 32'h1);
		pat_err_clr <= 1'h1;
		wait_c(1);
		pat_err_clr <= 1'h0;
		wait_c(4); check("pat_clr", 32'(lamp[0]), 32'h0);
	endtask : t_latch
	// A three-cycle event must outlast the stretch time unless bypassed
	task t_str;
		for (int i = 0; i < 6; i++) begin
			cfg({1'h0, 1'(i / 3), 2'h2, 8'h0, (i % 3 == 0) ? 4'h6 : 4'hb});
			pulse_clr;
			{tx_act, if_tx_err, if_rx_err} <= 3'h4 >> (i % 3);
			wait_c(3);
			{tx_act, if_tx_err, if_rx_err} <= 3'h0;
			wait_c(30);
			check("stretch", 32'((i < 3) ? lit[0] >= STR : lit[0] <= 4), 32'h1);
		end
	endtask : t_str
	initial begin
		wait_c(4);
		hresetn <= 1'h1;
		wait_c(1);
		t_regs;
		t_link;
		t_role;
		t_blink;
		t_latch;
		t_str;
		test_done;
	end
	// Hang guard well above the expected run length
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 30000) begin
			miscompares++;
			test_done;
		end
	end
endmodule : testbench
bind sild_top sild_checker sild_checker_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .link_up, .role_master, .lamp);
`default_nettype wire

// [src/sild_pkg.sv]
// Package of constants and types for the status indicator lamp block
package sild_pkg;

	// ****************************************************************
	// Register map: offsets are register indices, byte address is 4x
	// ****************************************************************
	localparam logic [11:0] SILD_IDX_CFG_MAIN = 12'h450;
	localparam logic [11:0] SILD_IDX_CFG_AUX  = 12'h451;
	localparam logic [15:0] SILD_RST_CFG_MAIN = 16'h2610;
	localparam logic [15:0] SILD_RST_CFG_AUX  = 16'h0000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SILD_POS_BYPASS = 14;
	localparam int SILD_POS_RATE   = 12;
	localparam int SILD_POS_SEL2   = 8;
	localparam int SILD_POS_SEL1   = 4;
	localparam int SILD_POS_SEL0   = 0;
	localparam int SILD_POS_DRVEN  = 2;
	localparam int SILD_POS_DRVVAL = 1;
	localparam int SILD_POS_POL    = 0;
	localparam int SILD_AUX_STRIDE = 3;
	localparam logic [15:0] SILD_MASK_MAIN = 16'h7fff;
	localparam logic [15:0] SILD_MASK_AUX  = 16'h01ff;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SILD_CLK_HZ      = 25000000;
	localparam int SILD_PER_MS_0    = 50;
	localparam int SILD_PER_MS_1    = 100;
	localparam int SILD_PER_MS_2    = 200;
	localparam int SILD_PER_MS_3    = 500;
	localparam int SILD_STRETCH_MS  = 50;
	localparam int SILD_CYC_PER_MS  = SILD_CLK_HZ / 1000;

	// ****************************************************************
	// Lamp source selector codes
	// ****************************************************************
	typedef enum logic [3:0] {
		SILD_SRC_LINK      = 4'b0000,
		SILD_SRC_ACT       = 4'b0001,
		SILD_SRC_TX        = 4'b0010,
		SILD_SRC_RX        = 4'b0011,
		SILD_SRC_MASTER    = 4'b0100,
		SILD_SRC_SLAVE     = 4'b0101,
		SILD_SRC_ACT_STR   = 4'b0110,
		SILD_SRC_RSV7      = 4'b0111,
		SILD_SRC_RSV8      = 4'b1000,
		SILD_SRC_LOST      = 4'b1001,
		SILD_SRC_PAT_ERR   = 4'b1010,
		SILD_SRC_IF_ERR    = 4'b1011
	} sild_src_t;

endpackage : sild_pkg

// [src/sild_stretch.sv]
// Pulse stretcher: holds a short event visible for a set time
`timescale 1ns/1ps
`default_nettype none
module sild_stretch #(
	parameter int HOLD_CYC = sild_pkg::SILD_STRETCH_MS * sild_pkg::SILD_CYC_PER_MS
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Event in, stretched out
	input  wire logic bypass,
	input  wire logic evt,
	output logic      stretched
);
	localparam int CW = $clog2(HOLD_CYC + 1);
	logic [CW-1:0] cnt_q;

	initial begin
		if (HOLD_CYC < 1) $error("sild_stretch: HOLD_CYC must be at least 1");
	end

	// Retrigger on each event so bursts look continuous
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (evt) begin
			cnt_q <= CW'(HOLD_CYC);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Bypass shows the raw event, may be too short to see
	assign stretched = bypass ? evt : (evt || cnt_q != '0);
endmodule : sild_stretch
`default_nettype wire

// [src/sild_top.sv]
// Status indicator lamp controller with AHB-Lite register slave
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sild_top
	import sild_pkg::*;
#(
	parameter int CLK_HZ     = sild_pkg::SILD_CLK_HZ,
	parameter int BLINK_UNIT = sild_pkg::SILD_CYC_PER_MS,
	parameter int STRETCH    = sild_pkg::SILD_STRETCH_MS * sild_pkg::SILD_CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [13:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Link state from the transceiver core
	input  wire logic        link_up,
	input  wire logic        role_master,
	input  wire logic        tx_act,
	input  wire logic        rx_act,
	input  wire logic        pat_err,
	input  wire logic        if_tx_err,
	input  wire logic        if_rx_err,
	// Side-band clears from other register blocks
	input  wire logic        status_rd,
	input  wire logic        pat_err_clr,
	// Lamp outputs
	output logic [2:0]       lamp
);
	import sild_pkg::*;

	// Refuse timing values the counters cannot serve
	initial begin
		if (BLINK_UNIT < 1 || STRETCH < 1 || CLK_HZ < 1000)
			$error("sild_top: timing parameters too small");
		if (SILD_PER_MS_3 / 2 > 1023)
			$error("sild_top: half period does not fit the ms counter");
	end

	// ****************************************************************
	// Register bus slave
	// ****************************************************************
	// Zero wait states: a write lands at the edge closing its data phase,
	// a read is fetched at its address edge and stands until the next read.
	// hsize is not decoded, since every register is one whole word.
	logic [15:0] cfg_main_q;
	logic [15:0] cfg_aux_q;
	logic [15:0] cfg_main_d;
	logic [15:0] cfg_aux_d;
	logic        wr_pend_q;
	logic [11:0] wr_idx_q;
	logic [31:0] rdata_q;

	// A transfer starts on NONSEQ or SEQ while the bus is ready
	logic        acc_valid;
	logic [11:0] acc_idx;
	assign acc_valid = hsel && hready && htrans[1];
	assign acc_idx   = haddr[13:2];

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// Capture address phase of a write
	// Write data comes one cycle later, in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
		end else begin
			wr_pend_q <= acc_valid && hwrite;
			wr_idx_q  <= acc_idx;
		end
	end

	// Next values of both words; a write lands at the edge closing its data phase
	always_comb begin
		cfg_main_d = cfg_main_q;
		cfg_aux_d  = cfg_aux_q;
		if (wr_pend_q && wr_idx_q == SILD_IDX_CFG_MAIN) begin
			cfg_main_d = hwdata[15:0] & SILD_MASK_MAIN;
		end
		if (wr_pend_q && wr_idx_q == SILD_IDX_CFG_AUX) begin
			cfg_aux_d = hwdata[15:0] & SILD_MASK_AUX;
		end
	end

	// Read data registered at address phase; unmapped reads as zero.
	// Taken from the next values, else a read right behind a write sees the old word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= '0;
		end else if (acc_valid && !hwrite) begin
			unique case (acc_idx)
				SILD_IDX_CFG_MAIN: rdata_q <= {16'h0000, cfg_main_d};
				SILD_IDX_CFG_AUX:  rdata_q <= {16'h0000, cfg_aux_d};
				default:           rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Main configuration; reserved bit 15 stays zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_main_q <= SILD_RST_CFG_MAIN;
		end else begin
			cfg_main_q <= cfg_main_d;
		end
	end

	// Auxiliary lamp force and polarity; bits 15:9 stay zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_aux_q <= SILD_RST_CFG_AUX;
		end else begin
			cfg_aux_q <= cfg_aux_d;
		end
	end

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	// Bypass and rate apply to all three lamps alike
	logic       bypass;
	logic [1:0] rate;
	logic [3:0] sel [3];
	assign bypass = cfg_main_q[SILD_POS_BYPASS];
	assign rate   = cfg_main_q[SILD_POS_RATE +: 2];
	assign sel[0] = cfg_main_q[SILD_POS_SEL0 +: 4];
	assign sel[1] = cfg_main_q[SILD_POS_SEL1 +: 4];
	assign sel[2] = cfg_main_q[SILD_POS_SEL2 +: 4];

	// ****************************************************************
	// Input synchronisers, three stages
	// ****************************************************************
	// Costs about five cycles of lamp latency, far below what an eye sees.
	// The two clears come from this clock and skip the stages.
	localparam int NIN = 7;
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] s1_q;
	logic [NIN-1:0] s2_q;
	logic [NIN-1:0] s3_q;
	logic [NIN-1:0] clean_q;
	assign raw_in = {if_rx_err, if_tx_err, pat_err, rx_act, tx_act, role_master, link_up};

	// Second and third stage must agree before a change is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= raw_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
		end
	end

	// Named views of the cleaned inputs
	logic lk;
	logic mst;
	logic txa;
	logic rxa;
	logic perr;
	logic ierr;
	assign lk   = clean_q[0];
	assign mst  = clean_q[1];
	assign txa  = clean_q[2];
	assign rxa  = clean_q[3];
	assign perr = clean_q[4];
	assign ierr = clean_q[5] | clean_q[6];

	// ****************************************************************
	// Blink timebase
	// ****************************************************************
	// Half period in milliseconds for each rate code
	function automatic logic [9:0] half_ms(input logic [1:0] r);
		unique case (r)
			2'b00: half_ms = 10'(SILD_PER_MS_0 / 2);
			2'b01: half_ms = 10'(SILD_PER_MS_1 / 2);
			2'b10: half_ms = 10'(SILD_PER_MS_2 / 2);
			2'b11: half_ms = 10'(SILD_PER_MS_3 / 2);
		endcase
	endfunction

	localparam int UW = $clog2(BLINK_UNIT + 1);
	logic [UW-1:0] unit_q;
	logic [9:0]    ms_q;
	logic          blink_q;
	logic          ms_tick;
	assign ms_tick = (unit_q == UW'(BLINK_UNIT - 1));

	// Millisecond prescaler
	// Free running, so the first blink after a rate change may start up to 1 ms late
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unit_q <= '0;
		end else begin
			unit_q <= ms_tick ? '0 : unit_q + 1'b1;
		end
	end

	// Square wave: half period on, half off
	// A rate change acts at once; the running half period may be cut short
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_q    <= '0;
			blink_q <= 1'b0;
		end else if (ms_tick) begin
			if (ms_q + 10'd1 >= half_ms(rate)) begin
				ms_q    <= '0;
				blink_q <= ~blink_q;
			end else begin
				ms_q <= ms_q + 10'd1;
			end
		end
	end

	// ****************************************************************
	// Activity and error stretching
	// ****************************************************************
	logic act_str;
	logic err_str;

	// Activity for code 6, stretched so a single frame is seen
	sild_stretch #(.HOLD_CYC(STRETCH)) u_act_str (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.bypass    (bypass),
		.evt       (txa | rxa),
		.stretched (act_str)
	);

	// Transmit or receive interface errors for code 11
	sild_stretch #(.HOLD_CYC(STRETCH)) u_err_str (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.bypass    (bypass),
		.evt       (ierr),
		.stretched (err_str)
	);

	// ****************************************************************
	// Sticky indications
	// ****************************************************************
	// Both latches outlive a selector change; only their own clear ends them
	logic lk_d_q;
	logic lost_q;
	logic perr_q;
	logic lk_fall;
	assign lk_fall = lk_d_q && !lk;

	// Set wins over clear so a drop during the read is not lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lk_d_q <= 1'b0;
			lost_q <= 1'b0;
		end else begin
			lk_d_q <= lk;
			if (lk_fall) begin
				lost_q <= 1'b1;
			end else if (status_rd) begin
				lost_q <= 1'b0;
			end
		end
	end

	// Checker error latch, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			perr_q <= 1'b0;
		end else if (perr) begin
			perr_q <= 1'b1;
		end else if (pat_err_clr) begin
			perr_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Lamp source selection and output
	// ****************************************************************
	// Source per selector code; only defined codes light a lamp
	function automatic logic lamp_src(input logic [3:0] s);
		// Blink phase gates activity so the lamp visibly flickers
		unique case (s)
			SILD_SRC_LINK:    lamp_src = lk;
			SILD_SRC_ACT:     lamp_src = lk && !((txa | rxa) && blink_q);
			SILD_SRC_TX:      lamp_src = lk && !(txa && blink_q);
			SILD_SRC_RX:      lamp_src = lk && !(rxa && blink_q);
			SILD_SRC_MASTER:  lamp_src = lk && mst;
			SILD_SRC_SLAVE:   lamp_src = lk && !mst;
			SILD_SRC_ACT_STR: lamp_src = act_str;
			SILD_SRC_LOST:    lamp_src = lost_q;
			SILD_SRC_PAT_ERR: lamp_src = perr_q;
			SILD_SRC_IF_ERR:  lamp_src = err_str;
			// Reserved codes 7, 8 and unused 12..15 keep the lamp dark
			default:          lamp_src = 1'b0;
		endcase
	endfunction

	// Registered lamp drive with force and polarity from aux register
	// Force and polarity act after selection, so a forced lamp ignores its source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lamp <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				lamp[i] <= (cfg_aux_q[i*SILD_AUX_STRIDE + SILD_POS_DRVEN]
					? cfg_aux_q[i*SILD_AUX_STRIDE + SILD_POS_DRVVAL]
					: lamp_src(sel[i]))
					^ cfg_aux_q[i*SILD_AUX_STRIDE + SILD_POS_POL];
			end
		end
	end

endmodule : sild_top
`default_nettype wire
